// File: tb/kgs_top_sva.sv
module kgs_top_sva (
	// Clock and reset
	input wire logic              mclk_in,
	input wire logic              sys_rst_in,
	// Bus
	input wire logic              wb_cyc_in,
	input wire logic              wb_stb_in,
	input wire logic              wb_we_in,
	input wire logic [7:0]        wb_adr_in,
	input wire logic [31:0]       wb_dat_out,
	input wire logic              wb_ack_out,
	// Gains and click
	input wire logic              play_frame_strobe_in,
	input wire logic              record_frame_strobe_in,
	input wire logic [6:0]        left_gain_out,
	input wire logic [6:0]        right_gain_out,
	input wire logic [6:0]        input_gain_out,
	input wire logic signed [4:0] keyclick_wave_out,
	input wire logic              keyclick_active_out
);
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (sys_rst_in);

	chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	chk_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack late");
	chk_ack_idle: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
		else $error("ack without request");
	chk_upper_zero: assert property (wb_ack_out && !wb_we_in |-> wb_dat_out[31:16] == 16'h0000)
		else $error("upper read bits set");
	chk_unmapped_zero: assert property (wb_ack_out && !wb_we_in &&
		!(wb_adr_in[7:2] inside {6'h01, 6'h02, 6'h03}) |-> wb_dat_out == 32'h0)
		else $error("unmapped read not zero");
	chk_left_step: assert property (!$stable(left_gain_out) |->
		7'(left_gain_out - $past(left_gain_out)) inside {7'h01, 7'h7F})
		else $error("left gain jumped");
	chk_right_step: assert property (!$stable(right_gain_out) |->
		7'(right_gain_out - $past(right_gain_out)) inside {7'h01, 7'h7F})
		else $error("right gain jumped");
	chk_input_step: assert property (!$stable(input_gain_out) |->
		7'(input_gain_out - $past(input_gain_out)) inside {7'h01, 7'h7F})
		else $error("input gain jumped");
	chk_left_strobe: assert property (!$stable(left_gain_out) |->
		$past(play_frame_strobe_in, 1) || $past(play_frame_strobe_in, 2) ||
		$past(play_frame_strobe_in, 3))
		else $error("left gain moved without strobe");
	chk_input_strobe: assert property (!$stable(input_gain_out) |->
		$past(play_frame_strobe_in, 2) || $past(record_frame_strobe_in, 2))
		else $error("input gain moved without strobe");
	chk_wave_idle: assert property (keyclick_wave_out != 5'sd0 |->
		keyclick_active_out || $past(keyclick_active_out))
		else $error("tone outside click");
	chk_wave_bound: assert property (keyclick_active_out |->
		keyclick_wave_out >= -5'sd8 && keyclick_wave_out <= 5'sd8)
		else $error("tone amplitude out of range");
endmodule

bind kgs_top kgs_top_sva u_sva (.mclk_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
	.wb_adr_in, .wb_dat_out, .wb_ack_out, .play_frame_strobe_in, .record_frame_strobe_in,
	.left_gain_out, .right_gain_out, .input_gain_out, .keyclick_wave_out,
	.keyclick_active_out);

// File: tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Short half period keeps every tone of the sweep affordable
	localparam int         HB   = 128;
	localparam logic [7:0] CTRL = kgs_pkg::REG_CTRL_OFS;
	localparam logic [7:0] STAT = kgs_pkg::REG_STAT_OFS;
	localparam logic [7:0] MASK = kgs_pkg::REG_MASK_OFS;
	logic              mclk_in, sys_rst_in, cyc, stb, we, pstb, rstb, agc_en, agc_nl;
	logic              ack, act, irq;
	logic [7:0]        adr;
	logic [3:0]        sel;
	logic [31:0]       dw, dr, q;
	logic [6:0]        tgt [3];
	logic [6:0]        gout [3];
	logic [6:0]        agc_tgt;
	logic signed [4:0] wave;
	logic [15:0]       lf = 16'h313D;
	int                n_mismatch = 0;
	int                compares = 0;
	int                cyc_cnt = 0;
	int                n;

	kgs_top #(.CLICK_HALF_BASE(19'(HB))) uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
		.wb_dat_in(dw), .wb_dat_out(dr), .wb_ack_out(ack), .play_frame_strobe_in(pstb),
		.record_frame_strobe_in(rstb), .left_gain_target_in(tgt[0]),
		.right_gain_target_in(tgt[1]), .input_gain_target_in(tgt[2]), .agc_enable_in(agc_en),
		.agc_gain_target_in(agc_tgt), .agc_noise_low_in(agc_nl), .left_gain_out(gout[0]),
		.right_gain_out(gout[1]), .input_gain_out(gout[2]), .keyclick_wave_out(wave),
		.keyclick_active_out(act), .irq_out(irq));

	initial begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [31:0] ctrl_word(input logic tr, input logic [2:0] lvl,
		input logic rate, input logic [2:0] tone, input logic [3:0] cnt);
		return {16'h0000, tr, lvl, rate, tone, cnt, 2'b00, rate, 1'b0};
	endfunction

	function automatic int click_len(input logic [2:0] tone, input logic [3:0] cnt);
		return 4 * (int'(cnt) + 1) * (HB >> tone);
	endfunction

	task automatic end_of_test();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge mclk_in) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 60000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge mclk_in);
	endtask

	// Classic cycle: held until ack is sampled, read data taken at that edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= d;
		sel <= 4'hF;
		tick(1);
		while (ack !== 1'b1 && k < 20) begin
			tick(1);
			k++;
		end
		check(32'(ack), 32'h1);
		q = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		tick(1);
	endtask

	task automatic strobe(input int i);
		if (i == 2)
			rstb <= 1'b1;
		else
			pstb <= 1'b1;
		tick(1);
		pstb <= 1'b0;
		rstb <= 1'b0;
		tick(3);
	endtask

	task automatic run_to(input int i, input logic [6:0] t);
		n = 0;
		while (gout[i] !== t && n < 200) begin
			strobe(i);
			n++;
		end
	endtask

	task automatic click(input logic [2:0] lvl, input logic [2:0] tone, input logic [3:0] cnt);
		int len, amp, w;
		len = 0;
		amp = 0;
		w = 0;
		bus(1'b1, CTRL, ctrl_word(1'b1, lvl, 1'b0, tone, cnt));
		while (act !== 1'b1 && w < 20) begin
			tick(1);
			w++;
		end
		while (act === 1'b1 && len < 20000) begin
			if (wave > amp)
				amp = wave;
			tick(1);
			len++;
		end
		check(len, click_len(tone, cnt));
		check(amp, int'(lvl) + 1);
		tick(3);
		bus(1'b0, CTRL, 32'h0);
		check(q[15], 1'b0);
	endtask

	task automatic step_test(input int i, input logic slow);
		logic [6:0] t;
		int d, b;
		lf = lfsr_next(lf);
		d = 2 + int'(lf[4:0]);
		t = (gout[i] >= 7'h40) ? gout[i] - 7'(d) : gout[i] + 7'(d);
		b = (i == 0) ? 3 : (i == 1) ? 2 : 0;
		bus(1'b1, CTRL, ctrl_word(1'b0, 3'h4, slow, 3'h4, 4'h1));
		tgt[i] <= t;
		tick(3);
		bus(1'b0, CTRL, 32'h0);
		check(q[b], 1'b0);
		run_to(i, t);
		check(n, slow ? 2 * d : d);
		bus(1'b0, CTRL, 32'h0);
		check(q[b], 1'b1);
	endtask

	initial begin
		sys_rst_in = 1'b1;
		{cyc, stb, we, pstb, rstb, agc_en, agc_nl} = 7'h00;
		adr = 8'h00;
		sel = 4'h0;
		dw = 32'h0;
		agc_tgt = 7'h00;
		tgt[0] = 7'h7F;
		tgt[1] = 7'h7F;
		tgt[2] = 7'h00;
		tick(4);
		sys_rst_in <= 1'b0;
		tick(3);
		bus(1'b0, CTRL, 32'h0);
		check(q[15:4], 12'h441);
		check(q[3:0], 4'hD);
		bus(1'b0, 8'h10, 32'h0);
		check(q, 32'h0);
		bus(1'b0, MASK, 32'h0);
		check(q, 32'h0);
		bus(1'b1, CTRL, 32'h0);
		bus(1'b0, CTRL, 32'h0);
		check(q, 32'h0000_000D);
		bus(1'b1, MASK, 32'h1);
		for (int t = 0; t < 8; t++) begin
			lf = lfsr_next(lf);
			click(lf[2:0], t[2:0], (t == 0) ? 4'h0 : (t == 7) ? 4'hF : lf[7:4]);
			check(irq, 1'b1);
			bus(1'b0, STAT, 32'h0);
			check(q[0], 1'b1);
			tick(2);
			check(irq, 1'b0);
			bus(1'b0, STAT, 32'h0);
			check(q[0], 1'b0);
		end
		// A masked event must leave the interrupt line quiet
		bus(1'b1, MASK, 32'h0);
		click(3'h7, 3'h7, 4'h0);
		check(irq, 1'b0);
		// Clearing the trigger cuts a long click short
		bus(1'b1, CTRL, ctrl_word(1'b1, 3'h2, 1'b0, 3'h0, 4'hF));
		tick(1);
		check(act, 1'b1);
		bus(1'b1, CTRL, ctrl_word(1'b0, 3'h2, 1'b0, 3'h0, 4'hF));
		tick(2);
		check(act, 1'b0);
		bus(1'b0, CTRL, 32'h0);
		check(q[15], 1'b0);
		step_test(0, 1'b0);
		step_test(1, 1'b1);
		step_test(2, 1'b1);
		step_test(2, 1'b0);
		agc_nl <= 1'b1;
		agc_en <= 1'b1;
		run_to(2, 7'h00);
		bus(1'b0, CTRL, 32'h0);
		check(q[0], 1'b1);
		check(q[11], 1'b1);
		bus(1'b0, STAT, 32'h0);
		check(q[5:4], 2'h3);
		agc_nl <= 1'b0;
		bus(1'b1, CTRL, ctrl_word(1'b0, 3'h4, 1'b1, 3'h4, 4'h1));
		bus(1'b0, CTRL, 32'h0);
		check(q[11], 1'b0);
		agc_tgt <= 7'h10;
		run_to(2, 7'h10);
		check(n, 16);
		bus(1'b0, CTRL, 32'h0);
		check(q[0], 1'b0);
		agc_tgt <= 7'h77;
		run_to(2, 7'h77);
		bus(1'b0, CTRL, 32'h0);
		check(q[0], 1'b1);
		agc_en <= 1'b0;
		end_of_test();
	end
endmodule

// File: verilog/kgs_click.sv
module kgs_click (
	// Clock and reset
	input  wire logic                               clk_in,
	input  wire logic                               rst_in,
	// Control
	input  wire logic                               start_in,
	input  wire logic                               stop_in,
	input  wire logic [2:0]                         tone_in,
	input  wire logic [3:0]                         count_in,
	input  wire logic [kgs_pkg::CLICK_HALF_W-1:0]   half_base_in,
	// Tone
	output logic                                    active_out,
	output logic                                    phase_out,
	output logic                                    done_out
);
	logic [kgs_pkg::CLICK_HALF_W-1:0]   half_cnt;
	logic [kgs_pkg::CLICK_HALVES_W-1:0] halves_left;

	wire [kgs_pkg::CLICK_HALF_W-1:0]   half_len  = half_base_in >> tone_in;
	// 2*(n+1) periods is 4*(n+1) half periods
	wire [kgs_pkg::CLICK_HALVES_W-1:0] halves_tot = {1'b0, count_in, 2'b00} + 7'h04;
	wire                               half_end   = (half_cnt == 19'h00001);
	wire                               last_half  = (halves_left == 7'h01);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			active_out  <= 1'b0;
			phase_out   <= 1'b0;
			done_out    <= 1'b0;
			half_cnt    <= '0;
			halves_left <= '0;
		end else begin
			done_out <= 1'b0;
			if (start_in) begin
				active_out  <= 1'b1;
				phase_out   <= 1'b1;
				half_cnt    <= half_len;
				halves_left <= halves_tot;
			end else if (stop_in) begin
				active_out <= 1'b0;
				phase_out  <= 1'b0;
			end else if (active_out && half_end) begin
				half_cnt    <= half_len;
				halves_left <= halves_left - 7'h01;
				phase_out   <= ~phase_out;
				if (last_half) begin
					active_out <= 1'b0;
					phase_out  <= 1'b0;
					done_out   <= 1'b1;
				end
			end else if (active_out) begin
				half_cnt <= half_cnt - 19'h00001;
			end
		end
	end
endmodule

// File: verilog/kgs_gain_step.sv
module kgs_gain_step #(
	parameter logic [kgs_pkg::GAIN_W-1:0] RESET_CODE = kgs_pkg::OUT_GAIN_RESET
) (
	// Clock and reset
	input  wire logic   clk_in,
	input  wire logic   rst_in,
	// Stepping port
	kgs_step_if.stepper s
);
	logic                       odd_frame;
	logic [kgs_pkg::GAIN_W-1:0] applied;
	logic                       settled;

	wire  step_now  = s.strobe && (!s.slow || odd_frame);
	wire  need_up   = applied < s.target;
	wire  need_down = applied > s.target;

	// One 0.5 dB code per step, always toward the target
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			odd_frame <= 1'b0;
			applied   <= RESET_CODE;
			settled   <= 1'b0;
		end else begin
			if (s.strobe)
				odd_frame <= s.slow ? ~odd_frame : 1'b0;
			if (step_now && need_up)
				applied <= applied + 7'h01;
			else if (step_now && need_down)
				applied <= applied - 7'h01;
			settled <= (applied == s.target);
		end
	end

	assign s.applied = applied;
	assign s.settled = settled;
endmodule

// File: verilog/kgs_pkg.sv
package kgs_pkg;

	// Clock
	localparam int          CLK_HZ              = 40_000_000;
	localparam int          CLK_PERIOD_NS       = 25;

	// Keyclick tone: code 000 is the base frequency, each code doubles it
	localparam int          CLICK_BASE_MHZ      = 62_500;
	localparam longint      CLICK_HALF_BASE_CYC =
		(longint'(CLK_HZ) * 64'd1000) / (64'd2 * longint'(CLICK_BASE_MHZ));
	localparam int          CLICK_HALF_W        = 19;
	localparam int          CLICK_HALVES_W      = 7;

	// Register map (byte addresses)
	localparam int          ADR_W               = 8;
	localparam logic [7:0]  REG_CTRL_OFS        = 8'h04;
	localparam logic [7:0]  REG_STAT_OFS        = 8'h08;
	localparam logic [7:0]  REG_MASK_OFS        = 8'h0C;

	// Control register fields
	localparam int          CTRL_W              = 16;
	localparam logic [15:0] CTRL_RESET          = 16'h4410;
	localparam int          CT_TRIG             = 15;
	localparam int          CT_LVL_LSB          = 12;
	localparam int          CT_IN_RATE          = 11;
	localparam int          CT_TONE_LSB         = 8;
	localparam int          CT_CNT_LSB          = 4;
	localparam int          CT_L_SET            = 3;
	localparam int          CT_R_SET            = 2;
	localparam int          CT_OUT_RATE         = 1;
	localparam int          CT_IN_SET           = 0;

	// Event status / mask fields
	localparam int          ST_W                = 6;
	localparam int          ST_CLICK_DONE       = 0;
	localparam int          ST_LEFT_SET         = 1;
	localparam int          ST_RIGHT_SET        = 2;
	localparam int          ST_IN_SET           = 3;
	localparam int          ST_SAT              = 4;
	localparam int          ST_NOISE            = 5;
	localparam logic [5:0]  STAT_RESET          = 6'h00;
	localparam logic [5:0]  MASK_RESET          = 6'h00;

	// Gain codes, 0.5 dB per code
	localparam int          GAIN_W              = 7;
	localparam logic [6:0]  OUT_GAIN_RESET      = 7'h7F;
	localparam logic [6:0]  IN_GAIN_RESET       = 7'h00;
	localparam logic [6:0]  AGC_SAT_LOW_CODE    = 7'h00;
	localparam logic [6:0]  AGC_SAT_MAX_CODE    = 7'h77;
	localparam int          NUM_PGA             = 3;

endpackage

// File: verilog/kgs_step_if.sv
interface kgs_step_if;
	logic                           strobe;
	logic                           slow;
	logic [kgs_pkg::GAIN_W-1:0]     target;
	logic [kgs_pkg::GAIN_W-1:0]     applied;
	logic                           settled;

	modport ctl (
		output strobe,
		output slow,
		output target,
		input  applied,
		input  settled
	);
	modport stepper (
		input  strobe,
		input  slow,
		input  target,
		output applied,
		output settled
	);
endinterface

// File: verilog/kgs_top.sv
// Notes on behaviour
// - Writing 1 to the trigger plays one click, then the bit self-clears.
// - Level field scales click amplitude, 000 lowest to 111 highest; resets 100.
// - Tone select gives 62.5 Hz doubling per code to 8 kHz; resets 100.
// - Period count n gives 2*(n+1) tone periods; resets 0001.
// - Input rate 0 steps input gain every frame strobe, 1 every second.
// - With AGC on, input rate bit is read-only and reads noise-low status.
// - Output rate 0 steps playback gains every frame, 1 every second.
// - Left settled flag reads 1 when applied left gain equals its target.
// - Right settled flag reads 1 when applied right gain equals its target.
// - Input settled flag reads 1 when input gain equals its target.
// - With AGC on, input settled flag reports saturation at low or max code.
//
// Our own choice: register access over Wishbone.
module kgs_top #(
	parameter logic [kgs_pkg::CLICK_HALF_W-1:0] CLICK_HALF_BASE =
		kgs_pkg::CLICK_HALF_W'(kgs_pkg::CLICK_HALF_BASE_CYC)
) (
	// Clock and reset
	input  wire logic                           mclk_in,
	input  wire logic                           sys_rst_in,
	// Wishbone slave
	input  wire logic                           wb_cyc_in,
	input  wire logic                           wb_stb_in,
	input  wire logic                           wb_we_in,
	input  wire logic [kgs_pkg::ADR_W-1:0]      wb_adr_in,
	input  wire logic [3:0]                     wb_sel_in,
	input  wire logic [31:0]                    wb_dat_in,
	output logic [31:0]                         wb_dat_out,
	output logic                                wb_ack_out,
	// Frame strobes
	input  wire logic                           play_frame_strobe_in,
	input  wire logic                           record_frame_strobe_in,
	// Gain targets and AGC
	input  wire logic [kgs_pkg::GAIN_W-1:0]     left_gain_target_in,
	input  wire logic [kgs_pkg::GAIN_W-1:0]     right_gain_target_in,
	input  wire logic [kgs_pkg::GAIN_W-1:0]     input_gain_target_in,
	input  wire logic                           agc_enable_in,
	input  wire logic [kgs_pkg::GAIN_W-1:0]     agc_gain_target_in,
	input  wire logic                           agc_noise_low_in,
	// Applied gains
	output logic [kgs_pkg::GAIN_W-1:0]          left_gain_out,
	output logic [kgs_pkg::GAIN_W-1:0]          right_gain_out,
	output logic [kgs_pkg::GAIN_W-1:0]          input_gain_out,
	// Keyclick
	output logic signed [4:0]                   keyclick_wave_out,
	output logic                                keyclick_active_out,
	// Interrupt
	output logic                                irq_out
);
	// Stored control bits; flag positions are never stored
	logic                       trig;
	logic [2:0]                 level;
	logic                       in_rate;
	logic [2:0]                 tone;
	logic [3:0]                 count;
	logic                       out_rate;
	logic [kgs_pkg::ST_W-1:0]   status;
	logic [kgs_pkg::ST_W-1:0]   mask;
	logic                       saturated;
	logic                       prev_l;
	logic                       prev_r;
	logic                       prev_in;
	logic                       prev_sat;
	logic                       prev_noise;

	// Bus decode
	wire        req        = wb_cyc_in && wb_stb_in;
	wire        take       = req && wb_ack_out;
	wire        hit_ctrl   = (wb_adr_in[7:2] == kgs_pkg::REG_CTRL_OFS[7:2]);
	wire        hit_stat   = (wb_adr_in[7:2] == kgs_pkg::REG_STAT_OFS[7:2]);
	wire        hit_mask   = (wb_adr_in[7:2] == kgs_pkg::REG_MASK_OFS[7:2]);
	wire        wr_ctrl_hi = take && wb_we_in && hit_ctrl && wb_sel_in[1];
	wire        wr_ctrl_lo = take && wb_we_in && hit_ctrl && wb_sel_in[0];
	wire        wr_mask    = take && wb_we_in && hit_mask && wb_sel_in[0];
	wire        rd_stat    = take && !wb_we_in && hit_stat;

	// Gain steppers
	kgs_step_if stp [kgs_pkg::NUM_PGA] ();

	genvar gi;
	generate
		for (gi = 0; gi < kgs_pkg::NUM_PGA; gi++) begin : g_pga
			kgs_gain_step #(
				.RESET_CODE ((gi == 2) ? kgs_pkg::IN_GAIN_RESET : kgs_pkg::OUT_GAIN_RESET)
			) u_step (
				.clk_in (mclk_in),
				.rst_in (sys_rst_in),
				.s      (stp[gi].stepper)
			);
		end
	endgenerate

	assign stp[0].strobe = play_frame_strobe_in;
	assign stp[0].slow   = out_rate;
	assign stp[0].target = left_gain_target_in;
	assign stp[1].strobe = play_frame_strobe_in;
	assign stp[1].slow   = out_rate;
	assign stp[1].target = right_gain_target_in;
	// Record PGA steps on either frame clock
	assign stp[2].strobe = play_frame_strobe_in || record_frame_strobe_in;
	assign stp[2].slow   = in_rate;
	assign stp[2].target = agc_enable_in ? agc_gain_target_in : input_gain_target_in;

	wire l_set  = stp[0].settled;
	wire r_set  = stp[1].settled;
	wire in_set = stp[2].settled;

	// Saturation when the AGC has driven the PGA to either end of its range
	wire sat_now = (stp[2].applied == kgs_pkg::AGC_SAT_LOW_CODE)
		|| (stp[2].applied == kgs_pkg::AGC_SAT_MAX_CODE);

	// Keyclick
	logic click_active;
	logic click_phase;
	logic click_done;
	wire  trig_wr1    = wr_ctrl_hi && wb_dat_in[kgs_pkg::CT_TRIG];
	wire  trig_wr0    = wr_ctrl_hi && !wb_dat_in[kgs_pkg::CT_TRIG];
	// Rewriting 1 while a click plays does not restart it
	wire  click_start = trig_wr1 && !(trig && !click_done);
	wire  click_stop  = trig_wr0 && trig;

	kgs_click u_click (
		.clk_in       (mclk_in),
		.rst_in       (sys_rst_in),
		.start_in     (click_start),
		.stop_in      (click_stop),
		.tone_in      (trig_wr1 ? wb_dat_in[10:8] : tone),
		.count_in     (trig_wr1 ? wb_dat_in[7:4] : count),
		.half_base_in (CLICK_HALF_BASE),
		.active_out   (click_active),
		.phase_out    (click_phase),
		.done_out     (click_done)
	);

	// Amplitude is level+1 so that code 000 still gives an audible click
	wire signed [4:0] amp       = signed'({2'b00, level}) + 5'sh01;
	wire signed [4:0] next_wave = !click_active ? 5'sh00 : (click_phase ? amp : -amp);

	// Read view of the control register
	wire in_rate_rd = agc_enable_in ? agc_noise_low_in : in_rate;
	wire in_set_rd  = agc_enable_in ? saturated : in_set;
	wire [15:0] ctrl_rd = {trig, level, in_rate_rd, tone, count,
		l_set, r_set, out_rate, in_set_rd};

	wire [31:0] rd_data = hit_ctrl ? {16'h0000, ctrl_rd} :
		hit_stat ? {26'h0, status} :
		hit_mask ? {26'h0, mask} : 32'h0000_0000;

	// Events: rising flags and click completion
	wire [kgs_pkg::ST_W-1:0] events = {
		agc_enable_in && agc_noise_low_in && !prev_noise,
		agc_enable_in && saturated && !prev_sat,
		in_set && !prev_in,
		r_set && !prev_r,
		l_set && !prev_l,
		click_done
	};
	// Only bits seen by the read are cleared; a new event wins over the clear
	wire [kgs_pkg::ST_W-1:0] clr_bits   = rd_stat ? wb_dat_out[kgs_pkg::ST_W-1:0] : '0;
	wire [kgs_pkg::ST_W-1:0] next_status = (status & ~clr_bits) | events;

	// Wishbone answer: ack one cycle after the request, data registered with it
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end else begin
			wb_ack_out <= req && !wb_ack_out;
			if (req && !wb_ack_out)
				wb_dat_out <= wb_we_in ? 32'h0000_0000 : rd_data;
		end
	end

	// Control register; flag bits in the write data are dropped
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			trig     <= kgs_pkg::CTRL_RESET[kgs_pkg::CT_TRIG];
			level    <= kgs_pkg::CTRL_RESET[14:12];
			in_rate  <= kgs_pkg::CTRL_RESET[kgs_pkg::CT_IN_RATE];
			tone     <= kgs_pkg::CTRL_RESET[10:8];
			count    <= kgs_pkg::CTRL_RESET[7:4];
			out_rate <= kgs_pkg::CTRL_RESET[kgs_pkg::CT_OUT_RATE];
		end else begin
			if (click_start)
				trig <= 1'b1;
			else if (click_done || click_stop)
				trig <= 1'b0;
			if (wr_ctrl_hi) begin
				level <= wb_dat_in[14:12];
				tone  <= wb_dat_in[10:8];
				if (!agc_enable_in)
					in_rate <= wb_dat_in[kgs_pkg::CT_IN_RATE];
			end
			if (wr_ctrl_lo) begin
				count    <= wb_dat_in[7:4];
				out_rate <= wb_dat_in[kgs_pkg::CT_OUT_RATE];
			end
		end
	end

	// Status, mask, edge history and interrupt
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			status     <= kgs_pkg::STAT_RESET;
			mask       <= kgs_pkg::MASK_RESET;
			saturated  <= 1'b0;
			prev_l     <= 1'b0;
			prev_r     <= 1'b0;
			prev_in    <= 1'b0;
			prev_sat   <= 1'b0;
			prev_noise <= 1'b0;
			irq_out    <= 1'b0;
		end else begin
			status     <= next_status;
			if (wr_mask)
				mask <= wb_dat_in[kgs_pkg::ST_W-1:0];
			saturated  <= agc_enable_in && sat_now;
			prev_l     <= l_set;
			prev_r     <= r_set;
			prev_in    <= in_set;
			prev_sat   <= agc_enable_in && saturated;
			prev_noise <= agc_enable_in && agc_noise_low_in;
			irq_out    <= |(next_status & mask);
		end
	end

	// Registered copies of the applied gains and the click waveform
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			left_gain_out       <= kgs_pkg::OUT_GAIN_RESET;
			right_gain_out      <= kgs_pkg::OUT_GAIN_RESET;
			input_gain_out      <= kgs_pkg::IN_GAIN_RESET;
			keyclick_wave_out   <= 5'sh00;
			keyclick_active_out <= 1'b0;
		end else begin
			left_gain_out       <= stp[0].applied;
			right_gain_out      <= stp[1].applied;
			input_gain_out      <= stp[2].applied;
			keyclick_wave_out   <= next_wave;
			keyclick_active_out <= click_active;
		end
	end
endmodule
